/* logic/hbl_pkg.sv */
// Shared constants for the host-side block link controller.
// Assumes a 125 MHz system clock and a byte-level serial port alongside.
package hbl_pkg;
    // ==========================================================
    // Clock and time base
    localparam int CLOCK_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLOCK_NS;
    localparam int TICK_W = 17;
    localparam int MS_W = 16;
    // ==========================================================
    // Guard and deadline times, in milliseconds
    localparam logic [15:0] HOST_GUARD_MS = 16'h0001;
    localparam logic [15:0] READER_GUARD_MS = 16'h0001;
    localparam logic [15:0] CHAR_GAP_MS = 16'h0032;
    localparam logic [15:0] B2B_EXTRA_MS = 16'h000A;
    localparam logic [15:0] B2B_GUARD_MS =
        (CHAR_GAP_MS + B2B_EXTRA_MS > READER_GUARD_MS) ?
        CHAR_GAP_MS + B2B_EXTRA_MS : READER_GUARD_MS;
    localparam logic [15:0] CARD_EXTRA_MS = 16'h000A;
    localparam logic [15:0] READER_DEADLINE_MS = 16'h01F4;
    localparam logic [15:0] RESEND_DEADLINE_MS = 16'h000A;
    // ==========================================================
    // Block format
    localparam logic [15:0] MAX_LEN = 16'h0103;
    localparam logic [15:0] HDR_BYTES = 16'h0003;
    localparam logic [7:0] TYPE_RESEND = 8'h80;
    localparam logic [7:0] SELF_DIAG_INS = 8'hF1;
    localparam int INS_POS = 1;
    localparam logic [7:0] CHECK_OK = 8'h00;
    localparam int ERR_BIT = 7;
    localparam logic [1:0] KIND_CHAR = 2'h0;
    localparam logic [1:0] KIND_GAP = 2'h1;
    localparam logic [1:0] KIND_OVERFLOW = 2'h2;
    localparam logic [1:0] KIND_CHECK = 2'h3;
    // ==========================================================
    // Payload buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    typedef enum {S_IDLE, S_LOAD, S_GUARD, S_TX, S_WAIT, S_RX} hbl_state_t;
endpackage

/* logic/hbl_host.sv */
// Host-side block link controller and its payload FIFO.
// Assumes a byte UART on the same clock doing character framing.
`timescale 1ns/1ps
`default_nettype none

module hbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

    assign out_data = mem[rd_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Flags are registered so both ready and valid come from flops
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_reg <= wr_reg + AW'(push);
            rd_reg <= rd_reg + AW'(pop);
            cnt_reg <= cnt_next;
            in_ready <= cnt_next != (AW+1)'(DEPTH);
            out_valid <= cnt_next != '0;
        end
    end
endmodule

module hbl_host #(
    parameter int TICK_CYCLES = hbl_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_type,
    input wire logic [15:0] cmd_len,
    input wire logic [15:0] card_time_ms,
    input wire logic [7:0] pay_data,
    input wire logic pay_valid,
    output logic pay_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_char_err,
    output logic [7:0] rsp_data,
    output logic rsp_data_valid,
    output logic rsp_done,
    output logic [7:0] rsp_type,
    output logic busy,
    output logic deadline_miss,
    output logic card_fail,
    output logic link_fault
);
    // ==========================================================
    // Decoders
    function automatic logic [7:0] pick_byte(input logic [15:0] idx,
            input logic [7:0] typ, input logic [15:0] len,
            input logic [7:0] body, input logic [7:0] chk);
        if (idx == 16'h0000) begin
            pick_byte = typ;
        end else if (idx == 16'h0001) begin
            pick_byte = len[15:8];
        end else if (idx == 16'h0002) begin
            pick_byte = len[7:0];
        end else if (idx == len + hbl_pkg::HDR_BYTES) begin
            pick_byte = chk;
        end else begin
            pick_byte = body;
        end
    endfunction

    localparam int TICK_W_L = hbl_pkg::TICK_W;
    hbl_pkg::hbl_state_t state_reg;
    logic [TICK_W_L-1:0] tick_reg;
    logic [15:0] since_ms_reg;
    logic [7:0] cmd_mem [0:259];
    logic [7:0] cmd_type_reg;
    logic [15:0] cmd_len_reg;
    logic [15:0] card_ms_reg;
    logic [7:0] send_type_reg;
    logic [15:0] send_len_reg;
    logic [15:0] ld_idx_reg;
    logic [15:0] idx_reg;
    logic [7:0] chk_reg;
    logic last_resp_reg;
    logic retry_reg;
    logic [15:0] rx_idx_reg;
    logic [15:0] rx_len_reg;
    logic [7:0] rx_chk_reg;
    logic [7:0] rx_type_reg;
    logic rx_bad_reg;
    logic [7:0] f_data;
    logic f_valid;

    wire is_idle = state_reg == hbl_pkg::S_IDLE;
    wire is_wait = state_reg == hbl_pkg::S_WAIT;
    wire is_rx = state_reg == hbl_pkg::S_RX;
    wire start_ok = cmd_start && (is_idle || is_wait) &&
        (cmd_type[7] || cmd_len <= hbl_pkg::MAX_LEN);
    wire [15:0] start_len = cmd_type[7] ? 16'h0000 : cmd_len;
    wire ld_done = ld_idx_reg == send_len_reg;
    wire f_ready = state_reg == hbl_pkg::S_LOAD && !ld_done;
    wire is_resend = send_type_reg[7];
    wire is_card = send_type_reg[7:6] == 2'b00;
    wire self_diag = send_type_reg[7:6] == 2'b01 &&
        send_len_reg > 16'(hbl_pkg::INS_POS) &&
        cmd_mem[hbl_pkg::INS_POS] == hbl_pkg::SELF_DIAG_INS;
    wire [15:0] guard_ms = last_resp_reg ? hbl_pkg::HOST_GUARD_MS
        : hbl_pkg::B2B_GUARD_MS;
    wire guard_met = since_ms_reg >= guard_ms;
    wire [15:0] deadline_ms = is_resend ? hbl_pkg::RESEND_DEADLINE_MS
        : !is_card ? hbl_pkg::READER_DEADLINE_MS
        : card_ms_reg + hbl_pkg::CARD_EXTRA_MS;
    wire deadline_hit = is_wait && !rx_valid && !start_ok &&
        !self_diag && since_ms_reg > deadline_ms;
    wire [15:0] last_idx = send_len_reg + hbl_pkg::HDR_BYTES;
    wire tx_hs = tx_valid && tx_ready;
    wire tx_last_hs = tx_hs && idx_reg == last_idx;
    wire [15:0] idx_inc = idx_reg + 16'h0001;
    wire [8:0] mem_addr = 9'(idx_inc - hbl_pkg::HDR_BYTES);
    wire [7:0] chk_next = chk_reg ^ tx_byte;
    wire [7:0] tx_following = pick_byte(idx_inc, send_type_reg,
        send_len_reg, cmd_mem[mem_addr], chk_next);
    wire rx_hs = rx_valid && (is_wait || is_rx);
    wire rx_last = rx_idx_reg >= hbl_pkg::HDR_BYTES &&
        rx_idx_reg == rx_len_reg + hbl_pkg::HDR_BYTES;
    wire rx_end = rx_hs && rx_last;
    wire rx_bad_blk = rx_bad_reg || rx_char_err ||
        (rx_chk_reg ^ rx_byte) != hbl_pkg::CHECK_OK;
    wire [1:0] rsp_kind = rx_type_reg[1:0];
    wire rsp_err = rx_type_reg[hbl_pkg::ERR_BIT];
    wire err_rsp = rsp_err && rsp_kind != hbl_pkg::KIND_OVERFLOW;
    wire gap_out = is_rx && !rx_valid &&
        since_ms_reg > hbl_pkg::CHAR_GAP_MS;
    wire link_err = gap_out || (rx_end && rx_bad_blk);
    wire timer_clr = tx_last_hs || rx_hs;

    hbl_fifo #(
        .WIDTH(hbl_pkg::FIFO_WIDTH),
        .DEPTH(hbl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data(pay_data),
        .in_valid(pay_valid),
        .in_ready(pay_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    // ==========================================================
    // Millisecond time base, restarted at the last sent byte and at every byte received while waiting or receiving
    always_ff @(posedge clock) begin
        if (rst || timer_clr) begin
            tick_reg <= '0;
            since_ms_reg <= '0;
        end else if (tick_reg == TICK_W_L'(TICK_CYCLES - 1)) begin
            tick_reg <= '0;
            if (since_ms_reg != 16'hFFFF) begin
                since_ms_reg <= since_ms_reg + 16'h0001;
            end
        end else begin
            tick_reg <= tick_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (f_valid && f_ready) begin
            cmd_mem[ld_idx_reg[8:0]] <= f_data;
        end
    end

    // ==========================================================
    // Response parser; bytes past the check are never looked at
    always_ff @(posedge clock) begin
        if (rst || state_reg == hbl_pkg::S_TX) begin
            rx_idx_reg <= '0;
            rx_len_reg <= '0;
            rx_chk_reg <= '0;
            rx_type_reg <= '0;
            rx_bad_reg <= 1'b0;
            rsp_data <= '0;
            rsp_data_valid <= 1'b0;
        end else begin
            rsp_data_valid <= rx_hs && !rx_last &&
                rx_idx_reg >= hbl_pkg::HDR_BYTES;
            if (rx_hs) begin
                rx_idx_reg <= rx_idx_reg + 16'h0001;
                rx_chk_reg <= rx_chk_reg ^ rx_byte;
                rx_bad_reg <= rx_bad_reg || rx_char_err;
                rsp_data <= rx_byte;
                if (rx_idx_reg == 16'h0000) begin
                    rx_type_reg <= rx_byte;
                end
                if (rx_idx_reg == 16'h0001) begin
                    rx_len_reg[15:8] <= rx_byte;
                end
                if (rx_idx_reg == 16'h0002) begin
                    rx_len_reg[7:0] <= rx_byte;
                end
            end
        end
    end

    // ==========================================================
    // Block sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= hbl_pkg::S_IDLE;
            cmd_type_reg <= '0;
            cmd_len_reg <= '0;
            card_ms_reg <= '0;
            send_type_reg <= '0;
            send_len_reg <= '0;
            ld_idx_reg <= '0;
            idx_reg <= '0;
            chk_reg <= '0;
            last_resp_reg <= 1'b1;
            retry_reg <= 1'b0;
            tx_byte <= '0;
            tx_valid <= 1'b0;
            rsp_done <= 1'b0;
            rsp_type <= '0;
            busy <= 1'b0;
            deadline_miss <= 1'b0;
            card_fail <= 1'b0;
            link_fault <= 1'b0;
        end else begin
            busy <= !is_idle;
            rsp_done <= 1'b0;
            deadline_miss <= 1'b0;
            card_fail <= 1'b0;
            link_fault <= 1'b0;
            if (start_ok) begin
                // A wait may be abandoned; guard then stays back-to-back
                cmd_type_reg <= cmd_type;
                cmd_len_reg <= start_len;
                card_ms_reg <= card_time_ms;
                send_type_reg <= cmd_type;
                send_len_reg <= start_len;
                ld_idx_reg <= '0;
                retry_reg <= 1'b0;
                state_reg <= hbl_pkg::S_LOAD;
            end else begin
                case (state_reg)
                    hbl_pkg::S_LOAD: begin
                        if (ld_done) begin
                            state_reg <= hbl_pkg::S_GUARD;
                        end else if (f_valid) begin
                            ld_idx_reg <= ld_idx_reg + 16'h0001;
                        end
                    end
                    hbl_pkg::S_GUARD: begin
                        if (guard_met) begin
                            idx_reg <= '0;
                            chk_reg <= '0;
                            tx_byte <= send_type_reg;
                            tx_valid <= 1'b1;
                            state_reg <= hbl_pkg::S_TX;
                        end
                    end
                    hbl_pkg::S_TX: begin
                        if (tx_last_hs) begin
                            tx_valid <= 1'b0;
                            last_resp_reg <= 1'b0;
                            state_reg <= hbl_pkg::S_WAIT;
                        end else if (tx_hs) begin
                            chk_reg <= chk_next;
                            idx_reg <= idx_inc;
                            tx_byte <= tx_following;
                        end
                    end
                    hbl_pkg::S_WAIT: begin
                        if (rx_valid) begin
                            state_reg <= rx_last ? hbl_pkg::S_IDLE
                                : hbl_pkg::S_RX;
                        end else if (deadline_hit) begin
                            deadline_miss <= 1'b1;
                            if (is_card) begin
                                card_fail <= 1'b1;
                                state_reg <= hbl_pkg::S_IDLE;
                            end else if (retry_reg) begin
                                link_fault <= 1'b1;
                                state_reg <= hbl_pkg::S_IDLE;
                            end else begin
                                retry_reg <= 1'b1;
                                state_reg <= hbl_pkg::S_GUARD;
                            end
                        end
                    end
                    hbl_pkg::S_RX: begin
                        if (link_err) begin
                            last_resp_reg <= 1'b1;
                            if (retry_reg) begin
                                link_fault <= 1'b1;
                                state_reg <= hbl_pkg::S_IDLE;
                            end else begin
                                retry_reg <= 1'b1;
                                send_type_reg <= hbl_pkg::TYPE_RESEND;
                                send_len_reg <= '0;
                                state_reg <= hbl_pkg::S_GUARD;
                            end
                        end else if (rx_end) begin
                            last_resp_reg <= 1'b1;
                            rsp_type <= rx_type_reg;
                            if (!rsp_err) begin
                                rsp_done <= 1'b1;
                                state_reg <= hbl_pkg::S_IDLE;
                            end else if (err_rsp && !retry_reg) begin
                                retry_reg <= 1'b1;
                                send_type_reg <= cmd_type_reg;
                                send_len_reg <= cmd_len_reg;
                                state_reg <= hbl_pkg::S_GUARD;
                            end else begin
                                link_fault <= 1'b1;
                                state_reg <= hbl_pkg::S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= hbl_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence bad_end_s;
        is_rx && rx_end && rx_bad_blk && !retry_reg && !start_ok;
    endsequence
    sequence err_end_s;
        is_rx && rx_end && !rx_bad_blk && err_rsp && !retry_reg &&
        !start_ok;
    endsequence
    sequence resend_armed_s;
        state_reg == hbl_pkg::S_GUARD &&
        send_type_reg == hbl_pkg::TYPE_RESEND && send_len_reg == 16'h0000;
    endsequence

    host_guard_a: assert property ($rose(tx_valid) && last_resp_reg
        |-> since_ms_reg >= 16'h0001)
        else $error("command sent within 1 ms of a response");
    b2b_guard_a: assert property ($rose(tx_valid) && !last_resp_reg
        |-> since_ms_reg >= 16'h003C)
        else $error("back-to-back command sent within 60 ms");
    deadline_flag_a: assert property ($rose(deadline_miss)
        |-> $past(is_wait) && $past(since_ms_reg) > $past(deadline_ms))
        else $error("deadline miss without an expired wait");
    self_diag_a: assert property (is_wait && self_diag
        |=> !deadline_miss)
        else $error("deadline run for self-diagnosis");
    resend_req_a: assert property (bad_end_s |=> resend_armed_s)
        else $error("faulty response did not arm a resend request");
    cmd_retry_a: assert property (err_end_s
        |=> state_reg == hbl_pkg::S_GUARD &&
            send_type_reg == $past(cmd_type_reg))
        else $error("error reply did not repeat the command");
    card_fail_a: assert property (deadline_hit && is_card
        |=> card_fail && is_idle)
        else $error("card deadline miss not reported");
    retry_once_a: assert property ($rose(link_fault) && $past(is_wait)
        |-> $past(retry_reg))
        else $error("timeout fault raised before one retry");
    char_gap_a: assert property (gap_out && !start_ok
        |=> !is_rx)
        else $error("char gap timeout not acted on");
    ms_step_a: assert property (!timer_clr && since_ms_reg != 16'hFFFF &&
        tick_reg == TICK_W_L'(TICK_CYCLES - 1)
        |=> since_ms_reg == $past(since_ms_reg) + 16'h0001)
        else $error("millisecond count missed a tick");
endmodule

`default_nettype wire

/* testbench/hbl_reader_model.sv */
// Behavioural reader answering the host link controller.
// Assumes the controller and this model share one clock.
`timescale 1ns/1ps
`default_nettype none
module hbl_reader_model #(
    parameter int TICK = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_char_err
);
    // ==========
    // Block capture
    logic [7:0] cmd[$];
    logic [7:0] blk[$];
    logic [7:0] last[$];
    logic [7:0] rsp[$];
    int mode = 0;
    int nbad = 0;
    int slow = 0;
    int got = 0;
    always @(posedge clock) begin
        tx_ready <= !rst && (slow == 0 || !tx_ready);
        if (rst) begin
            cmd.delete();
        end else if (tx_valid && tx_ready) begin
            cmd.push_back(tx_byte);
            if (cmd.size() > 3 && cmd.size() == {cmd[1], cmd[2]} + 4) begin
                blk = cmd;
                cmd.delete();
                got <= got + 1;
            end
        end
    end
    // ==========
    // Answering
    task automatic step(input logic [7:0] b, input logic v, input logic e);
        @(negedge clock);
        rx_byte = b;
        rx_valid = v;
        rx_char_err = e;
    endtask
    initial begin
        int g;
        int bad;
        logic [7:0] x;
        g = 0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_char_err = 1'b0;
        forever begin
            // Idle line toggles so a stale byte is never mistaken for data
            while (got == g) step(~rx_byte, 1'b0, 1'b0);
            g = got;
            repeat (TICK * (1 + 3 * slow)) step(~rx_byte, 1'b0, 1'b0);
            if (got != g) continue;
            x = 8'h00;
            foreach (blk[i]) x ^= blk[i];
            bad = 0;
            if (x != 8'h00) begin
                rsp = {8'h83, 8'h00, 8'h00};
            end else if (blk[0][7]) begin
                rsp = last;
            end else begin
                bad = nbad > 0 ? mode : 0;
                nbad = nbad > 0 ? nbad - 1 : 0;
                rsp = {8'h00, 8'h00, 8'h01, blk[blk.size() - 1]};
                if (bad inside {[2:5]})
                    rsp = {bad == 2 ? 8'hC0 : 8'h7E + 8'(bad), 8'h00, 8'h00};
            end
            if (bad == 1) continue;
            last = rsp;
            x = 8'h00;
            foreach (rsp[i]) x ^= rsp[i];
            rsp.push_back(bad == 6 ? ~x : x);
            foreach (rsp[i]) begin
                // Stall mid-block so the controller's char gap timer expires
                if (bad == 8 && i == 2) break;
                step(rsp[i], 1'b1, bad == 7 && i == 1);
                step(~rsp[i], 1'b0, 1'b0);
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the host link controller.
// Assumes the reader model sits on the far side of the link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TICK = 10;
    typedef struct {
        logic [7:0] typ;
        logic [15:0] len;
        logic [15:0] ct;
        logic [7:0] base;
        int mode;
        int nbad;
        int out;
        int dl;
    } hbl_row_t;
    // Outcome: 0 done, 1 link fault, 2 card failure
    hbl_row_t rows[13] = '{
        '{8'h00, 16'h0002, 16'h0003, 8'h20, 0, 0, 0, 0},
        '{8'h00, 16'h0000, 16'h0003, 8'h20, 0, 0, 0, 0},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 0, 0, 0, 0},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 2, 1, 0, 0},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 3, 1, 0, 0},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 5, 1, 0, 0},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 4, 1, 1, 0},
        '{8'h00, 16'h0003, 16'h0002, 8'h40, 6, 1, 0, 0},
        '{8'h00, 16'h0003, 16'h0002, 8'h40, 7, 1, 0, 0},
        '{8'h00, 16'h0002, 16'h0005, 8'h20, 1, 1, 2, 15},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 1, 1, 0, 500},
        '{8'h40, 16'h0004, 16'h0000, 8'h10, 1, 2, 1, 500},
        '{8'h00, 16'h0002, 16'h0003, 8'h20, 8, 1, 0, 0}
    };
    logic clock, rst, cmd_start, pay_valid, pay_ready, tx_valid, tx_ready;
    logic rx_valid, rx_char_err, rsp_data_valid, rsp_done, busy;
    logic deadline_miss, card_fail, link_fault;
    logic [7:0] cmd_type, pay_data, tx_byte, rx_byte, rsp_data, rsp_type;
    logic [15:0] cmd_len, card_time_ms;
    int n_fail = 0, n_checks = 0, cyc = 0, last_tx = 0, last_rx = 0;
    int cur_dl = 0, n_miss = 0;
    logic fresh = 1'b1, tv_d = 1'b0;
    logic [7:0] got_data = 8'h00;
    hbl_host #(.TICK_CYCLES(TICK)) hbl_host_i (
        .clock, .rst, .cmd_start, .cmd_type, .cmd_len, .card_time_ms,
        .pay_data, .pay_valid, .pay_ready, .tx_byte, .tx_valid, .tx_ready,
        .rx_byte, .rx_valid, .rx_char_err, .rsp_data, .rsp_data_valid,
        .rsp_done, .rsp_type, .busy, .deadline_miss, .card_fail, .link_fault
    );
    hbl_reader_model #(.TICK(TICK)) rdr_i (
        .clock, .rst, .tx_byte, .tx_valid, .tx_ready, .rx_byte, .rx_valid,
        .rx_char_err
    );
    // ==========
    // Helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] chk(input hbl_row_t r);
        logic [7:0] x;
        x = r.typ ^ r.len[15:8] ^ r.len[7:0];
        for (int i = 0; i < int'(r.len); i++) x ^= r.base + 8'(i);
        return x;
    endfunction
    task automatic push_byte(input logic [7:0] b);
        @(negedge clock);
        while (pay_ready !== 1'b1) @(negedge clock);
        pay_data = b;
        pay_valid = 1'b1;
        @(negedge clock);
        pay_valid = 1'b0;
    endtask
    task automatic run(input hbl_row_t r, input bit pre, input int lim,
                       output int res);
        for (int i = 0; i < int'(r.len) && !pre; i++) push_byte(r.base + 8'(i));
        @(negedge clock);
        cmd_type = r.typ;
        cmd_len = r.len;
        card_time_ms = r.ct;
        cmd_start = 1'b1;
        @(negedge clock);
        cmd_start = 1'b0;
        res = -1;
        for (int n = 0; n < lim && res < 0; n++) begin
            @(negedge clock);
            if (rsp_done === 1'b1) res = 0;
            else if (link_fault === 1'b1) res = 1;
            else if (card_fail === 1'b1) res = 2;
        end
    endtask
    // ==========
    // Link timing monitor
    always @(posedge clock) begin
        cyc <= cyc + 1;
        tv_d <= tx_valid;
        if (rx_valid) begin
            last_rx <= cyc;
            fresh <= 1'b1;
        end
        if (tx_valid && !tv_d) begin
            if (fresh)
                cmp(32'(cyc - last_rx >= TICK), 1);
            else
                cmp(32'(cyc - last_tx >= 60 * TICK), 1);
            fresh <= 1'b0;
        end
        if (tx_valid && tx_ready) last_tx <= cyc;
        if (rsp_data_valid) got_data <= rsp_data;
        if (deadline_miss) begin
            n_miss <= n_miss + 1;
            cmp(32'(cyc - last_tx > cur_dl * TICK), 1);
            cmp(32'(cyc - last_tx <= (cur_dl + 3) * TICK), 1);
        end
    end
    // ==========
    // Stimulus
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #(8 * 90000);
        n_fail++;
        test_done();
    end
    initial begin
        int res;
        int m;
        hbl_row_t r;
        rst = 1'b1;
        cmd_start = 1'b0;
        cmd_type = 8'h00;
        cmd_len = 16'h0000;
        card_time_ms = 16'h0000;
        pay_data = 8'h00;
        pay_valid = 1'b0;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        cmp(pay_ready, 1);
        cmp({busy, tx_valid, deadline_miss, link_fault}, 0);
        $display("test reset done");
        foreach (rows[k]) begin
            rdr_i.mode = rows[k].mode;
            rdr_i.nbad = rows[k].nbad;
            cur_dl = rows[k].dl;
            m = n_miss;
            run(rows[k], 1'b0, 20000, res);
            cmp(res, rows[k].out);
            // Let the monitor count the miss pulse before looking
            @(negedge clock);
            cmp(n_miss - m, rows[k].mode == 1 ? rows[k].nbad : 0);
            cmp(busy, 0);
            if (res == 0) begin
                cmp(rsp_type, 8'h00);
                cmp(got_data, chk(rows[k]));
            end
            if (rows[k].mode == 4) cmp(rsp_type, 8'h82);
            $display("test row %0d done", k);
        end
        // Silent self-diagnosis, then a new command abandons the wait
        r = '{8'h40, 16'h0004, 16'h0000, 8'hF0, 1, 1, 0, 0};
        for (int j = 0; j < 2; j++) begin
            r.base = 8'hF0;
            rdr_i.mode = 1;
            rdr_i.nbad = 1;
            m = n_miss;
            run(r, 1'b0, j ? 6000 : 100, res);
            cmp(res, -1);
            cmp(n_miss - m, 0);
            cmp(busy, 1);
            r.base = 8'h10;
            run(r, 1'b0, 20000, res);
            cmp(res, 0);
        end
        $display("test self diagnosis done");
        // Full buffer, then a stalling link drains it
        r.base = 8'h30;
        r.len = 16'h0010;
        for (int i = 0; i < 16; i++) push_byte(8'h30 + 8'(i));
        @(negedge clock);
        cmp(pay_ready, 0);
        rdr_i.slow = 1;
        run(r, 1'b1, 20000, res);
        cmp(res, 0);
        cmp(got_data, chk(r));
        cmp(pay_ready, 1);
        $display("test buffer done");
        test_done();
    end
endmodule
`default_nettype wire
